// ### sfrp_core.sv
/*
  Serial flash command sequencer for array reads and page programs.
  The link side runs on the host serial clock and chip select; the program
  engine runs on the system clock. Assumes an array read port on the link
  clock and an array write port with a done strobe on the system clock.
*/
// What this block does
// - Addresses are 24 bits, A23 to A0
// - Address bits sampled on rising serial clock
// - Read address increments after every output byte
// - Chip select high stops read output anytime
// - Read opcodes 03 0B 3B BB 6B EB
// - Single-lane protocol lane use per read opcode
// - Dual and quad protocols accept restricted reads
// - Fast reads insert dummy clocks before data
// - Dummy counts nine, seven, seven for quad/dual
// - Dual output fast read uses eight dummies
// - Select rise on boundary starts timed program
// - Unaligned program data wraps within the page
// - Overflowing bytes keep only the last page
// - Short program leaves other page bytes unchanged
// - Busy bit during program, write enable cleared
// - Program honours suspend and resume
// - Timeout clears write in progress, sets program fail
// - Select off boundary drops program silently
// - Protected sector: no program, flags one, four
// - Program lanes for address and data per opcode
// - Dual/quad program variants limited by protocol
`include "sfrp_defines.svh"
module sfrp_core #(
  parameter int unsigned PAGE_BYTES = 256, // Program page size
  parameter int unsigned SECTORS = 256, // Number of lockable sectors
  parameter int unsigned PP_TIMEOUT_CYC = `SFRP_T_PP_US * `SFRP_CLK_MHZ, // Program time in clocks
  parameter logic [7:0] OP_PP = 8'h02, // Page program opcode
  parameter logic [7:0] OP_DIFP = 8'hA2, // Dual input program opcode
  parameter logic [7:0] OP_EDIFP = 8'hD2, // Extended dual input program opcode
  parameter logic [7:0] OP_QIFP = 8'h32, // Quad input program opcode
  parameter logic [7:0] OP_EQIFP = 8'h12 // Extended quad input program opcode
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_dq,
  output logic [3:0] o_dq,
  output logic [3:0] o_dq_oe_n,
  input wire sfrp_pkg::sfrp_proto_e i_proto,
  output logic [`SFRP_ADDR_W-1:0] o_arr_rd_addr,
  input wire logic [7:0] i_arr_rd_data,
  input wire logic i_wel_set,
  input wire logic i_wel_clr,
  input wire logic i_flags_clr,
  input wire logic i_suspend,
  input wire logic i_resume,
  input wire logic [SECTORS-1:0] i_sect_lock,
  input wire logic i_arr_done,
  output sfrp_pkg::sfrp_pgm_s o_pgm,
  output logic o_arr_suspend,
  output logic o_wel,
  output logic o_wip,
  output logic [7:0] o_flags
);
  import sfrp_pkg::*;

  localparam int unsigned PG_W = $clog2(PAGE_BYTES); // Page index width
  localparam int unsigned TW = $clog2(PP_TIMEOUT_CYC + 1); // Timer width
  localparam int unsigned SW = $clog2(SECTORS); // Sector number width
  localparam logic [PG_W-1:0] PG_LAST = PG_W'(PAGE_BYTES - 1); // Last page index
  localparam logic [TW-1:0] TMO = TW'(PP_TIMEOUT_CYC); // Timeout count

  // Lane count of a protocol
  function automatic logic [2:0] lanes(input sfrp_proto_e pr);
    case (pr)
      SFRP_PROTO_EXT: lanes = `SFRP_L1;
      SFRP_PROTO_DUAL: lanes = `SFRP_L2;
      default: lanes = `SFRP_L4;
    endcase
  endfunction

  // Shift w lanes into the low end of a word
  function automatic logic [`SFRP_ADDR_W-1:0] shift_in(input logic [`SFRP_ADDR_W-1:0] v,
                                                      input logic [3:0] dq, input logic [2:0] w);
    case (w)
      `SFRP_L1: shift_in = {v[`SFRP_ADDR_W-2:0], dq[0]};
      `SFRP_L2: shift_in = {v[`SFRP_ADDR_W-3:0], dq[1:0]};
      default: shift_in = {v[`SFRP_ADDR_W-5:0], dq[3:0]};
    endcase
  endfunction

  // Opcode and protocol to acceptance, lanes and dummy count
  function automatic sfrp_cmd_s decode(input logic [7:0] op, input sfrp_proto_e pr);
    sfrp_cmd_s c;
    logic [2:0] pw;
    c = '0;
    pw = lanes(pr);
    c.alanes = pw;
    c.dlanes = pw;
    case (op)
      `SFRP_OP_READ: begin
        c.ok = (pr == SFRP_PROTO_EXT);
      end
      `SFRP_OP_FAST: begin
        c.ok = 1'b1;
        c.dummy = `SFRP_DUMMY_FAST;
      end
      `SFRP_OP_DOFR: begin
        c.ok = (pr != SFRP_PROTO_QUAD);
        c.dlanes = `SFRP_L2;
        c.dummy = `SFRP_DUMMY_DOFR;
      end
      `SFRP_OP_DIOFR: begin
        c.ok = (pr != SFRP_PROTO_QUAD);
        c.alanes = `SFRP_L2;
        c.dlanes = `SFRP_L2;
        c.dummy = `SFRP_DUMMY_DIOFR;
      end
      `SFRP_OP_QOFR: begin
        c.ok = (pr != SFRP_PROTO_DUAL);
        c.dlanes = `SFRP_L4;
        c.dummy = `SFRP_DUMMY_QOFR;
      end
      `SFRP_OP_QIOFR: begin
        c.ok = (pr != SFRP_PROTO_DUAL);
        c.alanes = `SFRP_L4;
        c.dlanes = `SFRP_L4;
        c.dummy = `SFRP_DUMMY_QIOFR;
      end
      OP_PP: begin // Lane 0 only in every protocol
        c.ok = 1'b1;
        c.is_prog = 1'b1;
        c.alanes = `SFRP_L1;
        c.dlanes = `SFRP_L1;
      end
      OP_DIFP, OP_EDIFP: begin
        c.ok = (pr != SFRP_PROTO_QUAD);
        c.is_prog = 1'b1;
        c.alanes = (op == OP_EDIFP) ? `SFRP_L2 : pw;
        c.dlanes = `SFRP_L2;
      end
      OP_QIFP, OP_EQIFP: begin
        c.ok = (pr != SFRP_PROTO_DUAL);
        c.is_prog = 1'b1;
        c.alanes = (op == OP_EQIFP) ? `SFRP_L4 : pw;
        c.dlanes = `SFRP_L4;
      end
      default: c.ok = 1'b0; // Unknown opcodes are ignored
    endcase
    return c;
  endfunction

  // ---------------- Link clock domain ----------------
  sfrp_lnk_e st_q; // Command phase
  logic [4:0] cnt_q; // Bit or dummy counter
  sfrp_cmd_s cmd_q; // Decoded command of this frame
  logic [`SFRP_ADDR_W-1:0] sh_q; // Opcode, address and data shifter
  logic [`SFRP_ADDR_W-1:0] sh_n; // Shifter next value
  logic [`SFRP_ADDR_W-1:0] rd_addr_q; // Array read address
  logic [7:0] out_sh_q; // Outgoing byte remainder
  logic byte_fresh_q; // Next output byte comes from the array
  logic [7:0] cur_byte; // Byte being shifted out
  sfrp_frame_s fr_q; // Frame result for the system side
  logic [PG_W:0] nbyt_q; // Program bytes received; low bits are added to the start address offset to give the slot
  logic [7:0] pbuf_q [PAGE_BYTES]; // Page buffer
  logic [PAGE_BYTES-1:0] pmask_q; // Bytes of the page to be written
  logic [PG_W-1:0] pidx; // Page slot of the incoming byte
  logic [2:0] w; // Lanes used in the current phase
  logic [4:0] cnt_n; // Counter after this edge
  logic byte_done; // A whole byte or opcode completes here
  logic addr_done; // Last address bit arrives here
  sfrp_cmd_s dec; // Decode of the arriving opcode
  logic [3:0] dqo_q; // Output lane values
  logic [3:0] oe_n_q; // Output lane enables

  // Phase lane width, counters and decode of the arriving opcode
  always_comb begin
    case (st_q)
      LK_CMD: w = lanes(i_proto);
      LK_ADDR: w = cmd_q.alanes;
      default: w = cmd_q.dlanes;
    endcase
    cnt_n = cnt_q + {2'h0, w};
    byte_done = (cnt_n == `SFRP_BYTE_BITS);
    addr_done = (st_q == LK_ADDR) && (cnt_n == `SFRP_ADDR_BITS);
    sh_n = shift_in(sh_q, i_dq, w);
    dec = decode(sh_n[7:0], i_proto);
    cur_byte = byte_fresh_q ? i_arr_rd_data : out_sh_q;
    pidx = fr_q.addr[PG_W-1:0] + nbyt_q[PG_W-1:0];
  end

  // Command phase sequencing, cleared whenever select is high
  always_ff @(posedge i_sclk or posedge i_rst or posedge i_cs_n) begin
    if (i_rst || i_cs_n) begin
      st_q <= LK_CMD;
      cnt_q <= '0;
      cmd_q <= '0;
    end else begin
      case (st_q)
        LK_CMD: begin
          cnt_q <= byte_done ? '0 : cnt_n;
          if (byte_done) begin
            cmd_q <= dec;
            st_q <= dec.ok ? LK_ADDR : LK_IGNORE;
          end
        end
        LK_ADDR: begin
          cnt_q <= addr_done ? '0 : cnt_n;
          if (addr_done) begin
            if (cmd_q.is_prog) begin
              st_q <= LK_PDATA;
            end else if (cmd_q.dummy != '0) begin
              st_q <= LK_DUMMY;
            end else begin
              st_q <= LK_RDATA;
            end
          end
        end
        LK_DUMMY: begin // One dummy per clock whatever the lanes
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q + 5'h01 == cmd_q.dummy) begin
            cnt_q <= '0;
            st_q <= LK_RDATA;
          end
        end
        LK_RDATA, LK_PDATA: begin
          cnt_q <= byte_done ? '0 : cnt_n;
        end
        default: st_q <= LK_IGNORE; // Rest of the frame is ignored
      endcase
    end
  end

  // Opcode, address and read stream datapath
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      sh_q <= '0;
      rd_addr_q <= '0;
      out_sh_q <= '0;
      byte_fresh_q <= 1'b0;
    end else begin
      if (st_q != LK_DUMMY) begin
        sh_q <= sh_n;
      end
      if (addr_done) begin
        rd_addr_q <= sh_n;
        byte_fresh_q <= 1'b1;
      end else if (st_q == LK_RDATA) begin
        if (byte_done) begin
          rd_addr_q <= rd_addr_q + 24'h000001;
          byte_fresh_q <= 1'b1;
        end else begin
          out_sh_q <= cur_byte << w;
          byte_fresh_q <= 1'b0;
        end
      end
    end
  end

  // Program frame capture: address, byte count, boundary and byte mask
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      fr_q <= '0;
      nbyt_q <= '0;
      pmask_q <= '0;
    end else if (st_q == LK_CMD && byte_done) begin
      fr_q <= '0; // New frame forgets the previous one
      nbyt_q <= '0;
      pmask_q <= '0;
    end else if (addr_done) begin
      fr_q.addr <= sh_n;
      fr_q.is_prog <= cmd_q.is_prog;
    end else if (st_q == LK_PDATA) begin
      fr_q.boundary <= byte_done;
      if (byte_done) begin
        pmask_q[pidx] <= 1'b1;
        // Slot index wraps, so a byte past one page lands on the oldest slot
        nbyt_q <= nbyt_q + 1'b1;
      end
    end
  end

  // Page buffer slots, later bytes overwrite earlier ones in the same slot
  always_ff @(posedge i_sclk) begin
    if (st_q == LK_PDATA && byte_done) begin
      pbuf_q[pidx] <= sh_n[7:0];
    end
  end

  // Output lanes change on the falling edge; select high releases them
  always_ff @(negedge i_sclk or posedge i_rst or posedge i_cs_n) begin
    if (i_rst || i_cs_n) begin
      dqo_q <= '0;
      oe_n_q <= `SFRP_OE_OFF;
    end else if (st_q == LK_RDATA) begin
      case (cmd_q.dlanes)
        `SFRP_L1: begin // Single lane output on lane one
          dqo_q <= {2'h0, cur_byte[7], 1'h0};
          oe_n_q <= `SFRP_OE_LANE1;
        end
        `SFRP_L2: begin
          dqo_q <= {2'h0, cur_byte[7:6]};
          oe_n_q <= `SFRP_OE_DUAL;
        end
        default: begin
          dqo_q <= cur_byte[7:4];
          oe_n_q <= `SFRP_OE_QUAD;
        end
      endcase
    end else begin
      oe_n_q <= `SFRP_OE_OFF;
    end
  end

  assign o_dq = dqo_q;
  assign o_dq_oe_n = oe_n_q;
  assign o_arr_rd_addr = rd_addr_q;

  // ---------------- System clock domain ----------------
  logic cs_s1_q; // Select synchroniser first stage
  logic cs_s2_q; // Select synchroniser second stage
  logic cs_s3_q; // Delayed copy for edge detection
  logic frame_end; // Select has just risen
  logic pgm_req; // Finished frame is a complete program
  logic prot_hit; // Target sector is locked
  logic go; // Program starts this cycle
  sfrp_sys_e sy_q; // Program engine phase
  logic [PG_W-1:0] widx_q; // Page slot being written
  logic [TW-1:0] tmr_q; // Program time counter
  logic susp_q; // Program suspended
  logic wel_q; // Write enable latch
  logic wip_q; // Write in progress
  logic pfail_q; // Program failure flag
  logic prot_q; // Protection error flag
  logic busy; // Engine is running and not suspended

  // Select crossing into the system clock
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else if (i_ce) begin
      cs_s1_q <= i_cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  // Frame results are stable while select stays high and the clock stands
  always_comb begin
    frame_end = cs_s2_q && !cs_s3_q;
    pgm_req = frame_end && fr_q.is_prog && fr_q.boundary;
    prot_hit = i_sect_lock[fr_q.addr[`SFRP_SECT_LSB +: SW]];
    go = pgm_req && wel_q && (sy_q == SY_IDLE) && !prot_hit;
    busy = (sy_q != SY_IDLE) && !susp_q;
  end

  // Program engine: stream the page, then wait for done or timeout
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sy_q <= SY_IDLE;
      widx_q <= '0;
      tmr_q <= '0;
      o_pgm <= '0;
    end else if (i_ce) begin
      o_pgm.we <= 1'b0;
      if (busy) begin
        tmr_q <= tmr_q + 1'b1; // Time frozen while suspended
      end
      case (sy_q)
        SY_IDLE: begin
          if (go) begin
            sy_q <= SY_WRITE;
            widx_q <= '0;
            tmr_q <= '0;
          end
        end
        SY_WRITE: begin
          if (!susp_q) begin
            o_pgm.we <= pmask_q[widx_q];
            o_pgm.addr <= {fr_q.addr[`SFRP_ADDR_W-1:PG_W], widx_q};
            o_pgm.data <= pbuf_q[widx_q];
            widx_q <= widx_q + 1'b1;
            if (widx_q == PG_LAST) begin
              sy_q <= SY_WAIT;
            end
          end
        end
        SY_WAIT: begin
          if (i_arr_done || (busy && tmr_q == TMO)) begin
            sy_q <= SY_IDLE;
          end
        end
        default: sy_q <= SY_IDLE;
      endcase
    end
  end

  // Suspend and resume of a running program
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      susp_q <= 1'b0;
    end else if (i_ce) begin
      if (sy_q == SY_IDLE) begin
        susp_q <= 1'b0;
      end else if (i_suspend) begin
        susp_q <= 1'b1;
      end else if (i_resume) begin
        susp_q <= 1'b0;
      end
    end
  end

  // Write enable latch and write in progress
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wel_q <= 1'b0;
      wip_q <= 1'b0;
    end else if (i_ce) begin
      if (go) begin
        wel_q <= 1'b0;
        wip_q <= 1'b1;
      end else begin
        if (i_wel_set) begin
          wel_q <= 1'b1;
        end else if (i_wel_clr) begin
          wel_q <= 1'b0;
        end
        if (sy_q == SY_WAIT && (i_arr_done || (busy && tmr_q == TMO))) begin
          wip_q <= 1'b0;
        end
      end
    end
  end

  // Error flags; a setting event wins over a clear in the same cycle
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pfail_q <= 1'b0;
      prot_q <= 1'b0;
    end else if (i_ce) begin
      if (sy_q == SY_WAIT && !i_arr_done && busy && tmr_q == TMO) begin
        pfail_q <= 1'b1;
      end else if (pgm_req && wel_q && sy_q == SY_IDLE && prot_hit) begin
        pfail_q <= 1'b1;
      end else if (i_flags_clr) begin
        pfail_q <= 1'b0;
      end
      if (pgm_req && wel_q && sy_q == SY_IDLE && prot_hit) begin
        prot_q <= 1'b1;
      end else if (i_flags_clr) begin
        prot_q <= 1'b0;
      end
    end
  end

  // Status outputs
  always_comb begin
    o_flags = '0;
    o_flags[`SFRP_FS_PROT] = prot_q;
    o_flags[`SFRP_FS_SUSP] = susp_q;
    o_flags[`SFRP_FS_PFAIL] = pfail_q;
    o_flags[`SFRP_FS_READY] = !wip_q || susp_q;
    o_wel = wel_q;
    o_wip = wip_q;
    o_arr_suspend = susp_q;
  end

  // ---------------- Checks ----------------
  addr_capture_a: assert property (@(posedge i_sclk) disable iff (i_rst)
    addr_done |=> rd_addr_q == $past(sh_n)) else $error("read address not captured");
  addr_incr_a: assert property (@(posedge i_sclk) disable iff (i_rst)
    st_q == LK_RDATA && byte_done && !i_cs_n |=> rd_addr_q == $past(rd_addr_q) + 24'h000001)
    else $error("read address did not step");
  cs_release_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    cs_s1_q && cs_s2_q |-> o_dq_oe_n == `SFRP_OE_OFF) else $error("lanes driven while deselected");
  proto_refuse_a: assert property (@(posedge i_sclk) disable iff (i_rst)
    st_q == LK_CMD && byte_done && !dec.ok && !i_cs_n |=> st_q == LK_IGNORE)
    else $error("unsupported opcode accepted");
  dummy_enter_a: assert property (@(posedge i_sclk) disable iff (i_rst)
    addr_done && !cmd_q.is_prog && cmd_q.dummy != '0 && !i_cs_n |=> st_q == LK_DUMMY)
    else $error("dummy phase skipped");
  quad_dummy_a: assert property (@(posedge i_sclk) disable iff (i_rst)
    st_q == LK_CMD && byte_done && sh_n[7:0] == `SFRP_OP_QIOFR && !i_cs_n |=> cmd_q.dummy == `SFRP_DUMMY_QIOFR)
    else $error("quad io dummy count wrong");
  dual_dummy_a: assert property (@(posedge i_sclk) disable iff (i_rst)
    st_q == LK_CMD && byte_done && sh_n[7:0] == `SFRP_OP_DOFR && !i_cs_n |=> cmd_q.dummy == `SFRP_DUMMY_DOFR)
    else $error("dual output dummy count wrong");
  prog_start_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    go && i_ce |=> wip_q && !wel_q && sy_q == SY_WRITE) else $error("program did not start");
  short_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    sy_q == SY_WRITE && !susp_q && i_ce && !pmask_q[widx_q] |=> !o_pgm.we)
    else $error("unsent byte written");
  suspend_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    sy_q != SY_IDLE && i_suspend && i_ce |=> susp_q ##1 (!i_ce || i_resume || sy_q == SY_IDLE
    || $stable(tmr_q))) else $error("suspend did not freeze program");
  timeout_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    sy_q == SY_WAIT && busy && tmr_q == TMO && !i_arr_done && i_ce |=> pfail_q && !wip_q && !wel_q)
    else $error("timeout not flagged");
  no_boundary_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    frame_end && fr_q.is_prog && !fr_q.boundary && sy_q == SY_IDLE && i_ce && !i_wel_set && !i_wel_clr
    |=> sy_q == SY_IDLE && wel_q == $past(wel_q) && !wip_q) else $error("partial program ran");
  protect_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    pgm_req && wel_q && sy_q == SY_IDLE && prot_hit && i_ce |=> wel_q && prot_q && pfail_q
    && sy_q == SY_IDLE) else $error("protected program not refused");
  read_byte_c: cover property (@(posedge i_sclk) disable iff (i_rst) st_q == LK_RDATA && byte_done);
  prog_done_c: cover property (@(posedge i_clk_sys) disable iff (i_rst) sy_q == SY_WAIT && i_arr_done);
  suspend_c: cover property (@(posedge i_clk_sys) disable iff (i_rst) susp_q ##1 !susp_q);
endmodule

// ### sfrp_defines.svh
/*
  Constants of the serial flash read and page program sequencer: opcodes,
  dummy counts, lane counts, flag bit positions, sector field and timing.
  Assumes inclusion by bare name from the package and the core module.
*/
`ifndef SFRP_DEFINES_SVH
`define SFRP_DEFINES_SVH
// Address field width in bits
`define SFRP_ADDR_W 24
// Read opcodes
`define SFRP_OP_READ 8'h03
`define SFRP_OP_FAST 8'h0B
`define SFRP_OP_DOFR 8'h3B
`define SFRP_OP_DIOFR 8'hBB
`define SFRP_OP_QOFR 8'h6B
`define SFRP_OP_QIOFR 8'hEB
// Dummy clock counts of the fast reads
`define SFRP_DUMMY_FAST 5'h08
`define SFRP_DUMMY_DOFR 5'h08
`define SFRP_DUMMY_DIOFR 5'h07
`define SFRP_DUMMY_QOFR 5'h07
`define SFRP_DUMMY_QIOFR 5'h09
// Lane counts
`define SFRP_L1 3'h1
`define SFRP_L2 3'h2
`define SFRP_L4 3'h4
// Bits per byte and address bits per frame, as counter values
`define SFRP_BYTE_BITS 5'h08
`define SFRP_ADDR_BITS 5'h18
// Output enables, active low, per lane group
`define SFRP_OE_OFF 4'hF
`define SFRP_OE_LANE1 4'hD
`define SFRP_OE_DUAL 4'hC
`define SFRP_OE_QUAD 4'h0
// Flag status bit positions
`define SFRP_FS_PROT 1
`define SFRP_FS_SUSP 2
`define SFRP_FS_PFAIL 4
`define SFRP_FS_READY 7
// Sector number field of the address
`define SFRP_SECT_LSB 16
// Page program time in microseconds and system clock in MHz
`define SFRP_T_PP_US 5000
`define SFRP_CLK_MHZ 20
`endif

// ### sfrp_pkg.sv
/*
  Types of the serial flash read and page program sequencer.
  Assumes sfrp_defines.svh is on the include path.
*/
`include "sfrp_defines.svh"
package sfrp_pkg;
  // Lane protocol selected for the link
  typedef enum logic [1:0] {SFRP_PROTO_EXT, SFRP_PROTO_DUAL, SFRP_PROTO_QUAD} sfrp_proto_e;
  // Link side command phases
  typedef enum logic [2:0] {LK_CMD, LK_ADDR, LK_DUMMY, LK_RDATA, LK_PDATA, LK_IGNORE} sfrp_lnk_e;
  // System side program phases
  typedef enum logic [1:0] {SY_IDLE, SY_WRITE, SY_WAIT} sfrp_sys_e;
  // Decoded command: accepted, program or read, lanes and dummy count
  typedef struct packed {
    logic ok;
    logic is_prog;
    logic [2:0] alanes;
    logic [2:0] dlanes;
    logic [4:0] dummy;
  } sfrp_cmd_s;
  // Result of a finished frame handed to the system side
  typedef struct packed {
    logic [`SFRP_ADDR_W-1:0] addr;
    logic is_prog;
    logic boundary;
  } sfrp_frame_s;
  // One byte write towards the array
  typedef struct packed {
    logic we;
    logic [`SFRP_ADDR_W-1:0] addr;
    logic [7:0] data;
  } sfrp_pgm_s;
endpackage

// ### sfrp_host.sv
/* Host model of the serial link: select, link clock, lanes.
   Assumes a device sampling lanes on the rising link clock. */
module sfrp_host (
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_dq,
  input wire logic [3:0] i_dq
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_sclk = 0;
    o_cs_n = 1;
    o_dq = 0;
  end
  // Select change; gap after release lets the system side settle
  task sel(input logic v);
    #80 o_cs_n = v;
    if (v) #400;
  endtask
  // Send n bits MSB first on w lanes, one 160 ns link clock each
  task shift(input logic [31:0] v, input int n, input int w);
    for (int i = n - w; i >= 0; i -= w) begin
      o_dq = ~o_dq;
      for (int k = 0; k < w; k++) o_dq[k] = v[i+k];
      #80 o_sclk = 1;
      #80 o_sclk = 0;
    end
  endtask
  // Take one byte on the read lanes at rising edges
  task get(output logic [7:0] b, input int w);
    repeat (8 / w) begin
      #80 o_sclk = 1;
      b = (w == 4) ? {b[3:0], i_dq} : (w == 2) ? {b[5:0], i_dq[1:0]} : {b[6:0], i_dq[1]};
      #80 o_sclk = 0;
    end
  endtask
endmodule

// ### serial_flash_read_program_test.sv
/* Testbench of the read and page program sequencer.
   Assumes sfrp_pkg compiled first and the host model beside it. */
module serial_flash_read_program_test;
  import sfrp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wset = 0, wclr = 0, fclr = 0, susp = 0, res = 0, done = 0, ce = 1, sclk, cs_n;
  logic [3:0] hdq, ddq, oe_n;
  logic [255:0] lock = 0;
  logic [23:0] ra;
  logic [7:0] b, fl;
  logic wel, wip, asp;
  sfrp_proto_e proto = SFRP_PROTO_EXT;
  sfrp_pgm_s pgm;
  int error_cnt = 0, check_count = 0, npg = 0;
  // Rows: opcode, protocol, cmd lanes, addr lanes, dummies, data lanes
  logic [31:0] rows[11] = '{32'h03011001, 32'h0B011081, 32'h3B011082, 32'hBB012072, 32'h6B011074,
    32'hEB014094, 32'h0B122082, 32'hBB122072, 32'h0B244084, 32'h6B244074, 32'hEB244094};
  always #25 clk = ~clk;
  // Released lanes float high through pull-ups
  sfrp_host u_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_dq(hdq), .i_dq(ddq | oe_n));
  sfrp_core #(.PP_TIMEOUT_CYC(400)) u_dut (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_dq(hdq), .o_dq(ddq), .o_dq_oe_n(oe_n), .i_proto(proto), .o_arr_rd_addr(ra),
    .i_arr_rd_data(ra[7:0] ^ 8'hA5), .i_wel_set(wset), .i_wel_clr(wclr), .i_flags_clr(fclr),
    .i_suspend(susp), .i_resume(res), .i_sect_lock(lock), .i_arr_done(done), .o_pgm(pgm),
    .o_arr_suspend(asp), .o_wel(wel), .o_wip(wip), .o_flags(fl));
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic waitv(input logic v);
    int n;
    for (n = 0; n < 600 && wip !== v; n++) @(negedge clk);
    if (n == 600) begin
      error_cnt++;
      close_out();
    end
  endtask
  // Written bytes carry data equal to slot xor 3C, with address bits 15:8 equal to 02
  always @(negedge clk) if (pgm.we) begin
    npg++;
    chk("pgm data", pgm.addr[7:0] ^ 8'h3C, pgm.data);
    chk("pgm page", 8'h02, pgm.addr[15:8]);
  end
  // Page program of nb bytes from 0102FE, plus extra stray bits
  task automatic prog(input int nb, input int extra);
    @(negedge clk) wset = 1;
    @(negedge clk) wset = 0;
    u_host.sel(0);
    u_host.shift(32'h02, 8, 1);
    u_host.shift(32'h0102FE, 24, 1);
    for (int i = 0; i < nb; i++) u_host.shift({24'h0, 8'hFE + 8'(i) ^ 8'h3C}, 8, 1);
    u_host.shift(0, extra, 1);
    u_host.sel(1);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    chk("reset flags", 8'h80, fl);
    rst = 0;
    foreach (rows[r]) begin
      proto = sfrp_proto_e'(rows[r][21:20]);
      u_host.sel(0);
      u_host.shift(rows[r][31:24], 8, rows[r][19:16]);
      u_host.shift(32'h1234FF, 24, rows[r][15:12]);
      u_host.shift(0, rows[r][11:4], 1);
      u_host.get(b, rows[r][3:0]);
      chk("read byte", 8'h5A, b);
      u_host.get(b, rows[r][3:0]);
      chk("next byte", 8'hA5, b);
      u_host.sel(1);
      chk("released", 8'h0F, oe_n);
    end
    $display("read table done");
    proto = SFRP_PROTO_DUAL;
    u_host.sel(0);
    u_host.shift(32'h03, 8, 2);
    u_host.shift(32'h1234FF, 24, 2);
    u_host.get(b, 2);
    chk("refused oe", 8'h0F, oe_n);
    chk("refused data", 8'hFF, b);
    u_host.sel(1);
    proto = SFRP_PROTO_EXT;
    prog(3, 0);
    waitv(1);
    chk("wel busy", 8'h00, wel);
    repeat (262) @(negedge clk);
    chk("bytes", 8'h03, 8'(npg));
    done = 1;
    @(negedge clk) done = 0;
    @(negedge clk);
    chk("done", 8'h80, fl);
    chk("wip low", 8'h00, {7'h0, wip});
    $display("program done");
    prog(258, 0);
    waitv(1);
    susp = 1;
    @(negedge clk) susp = 0;
    @(negedge clk);
    chk("susp", 8'h84, fl);
    chk("susp out", 8'h01, {7'h0, asp});
    res = 1;
    @(negedge clk) res = 0;
    waitv(0);
    chk("timeout", 8'h90, {~wel, fl[6:0]});
    fclr = 1;
    @(negedge clk) fclr = 0;
    lock[1] = 1;
    prog(1, 0);
    repeat (8) @(negedge clk);
    chk("protect", 8'h93, {fl[7:1], wel});
    fclr = 1;
    @(negedge clk) fclr = 0;
    lock[1] = 0;
    prog(1, 3);
    repeat (8) @(negedge clk);
    chk("off boundary", 8'h81, {fl[7:1], wel | wip});
    ce = 0;
    wclr = 1;
    @(negedge clk) wclr = 0;
    ce = 1;
    chk("ce hold", 8'h01, {7'h0, wel});
    wclr = 1;
    @(negedge clk) wclr = 0;
    chk("wel clr", 8'h00, {7'h0, wel});
    $display("status cases done");
    close_out();
  end
endmodule
